/* File: include/ccb_defines.svh */
// constants for the can clocking front end
`ifndef CCB_DEFINES_SVH
`define CCB_DEFINES_SVH
// ==========================================
// register offsets (8-bit sfr style address)
`define CCB_ADDR_CLK_CFG   8'h00
`define CCB_ADDR_BRP_EXT   8'h01
`define CCB_ADDR_SEG_PROP  8'h02
`define CCB_ADDR_SEG_PH1   8'h03
`define CCB_ADDR_SEG_PH2   8'h04
`define CCB_ADDR_STATUS    8'h05
`define CCB_ADDR_SCRATCH   8'h06
// ==========================================
// field layout and reset values
`define CCB_DIV_LSB        0
`define CCB_DIV_MSB        1
`define CCB_EN_BIT         7
`define CCB_CFG_RESET      8'h00
`define CCB_BRP_RESET      8'h00
`define CCB_PROP_RESET     8'h01
`define CCB_PH1_RESET      8'h03
`define CCB_PH2_RESET      8'h02
`define CCB_SYNC_TQ        8'h01
// ==========================================
// timing
`define CCB_SYS_MHZ        250
`define CCB_CAN_MAX_MHZ    25
// post-write read window per ratio, in system clock cycles
`define CCB_WAIT_DIV1      3'h0
`define CCB_WAIT_DIV2      3'h1
`define CCB_WAIT_DIV4      3'h3
`define CCB_WAIT_DIV8      3'h7
`endif

/* File: include/ccb_pkg.sv */
// types for the can clocking front end
package ccb_pkg;
  // ==========================================
  // divider ratio encoding
  typedef enum logic [1:0] {
    CCB_DIV1 = 2'h0,
    CCB_DIV2 = 2'h1,
    CCB_DIV4 = 2'h2,
    CCB_DIV8 = 2'h3
  } ccb_div_e;
  // ==========================================
  // bit segment states, gray along the bit
  typedef enum logic [1:0] {
    CCB_SYNC  = 2'h0,
    CCB_PROP  = 2'h1,
    CCB_PH1   = 2'h3,
    CCB_PH2   = 2'h2
  } ccb_seg_e;
endpackage : ccb_pkg

/* File: hdl/ccb_clk_div.sv */
// can clock divider: one-cycle enable at system_clock / ratio
`timescale 1ns/1ps
module ccb_clk_div
  import ccb_pkg::*;
(
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  // ratio select
  input  wire ccb_div_e   div_sel,
  // enable out
  output      logic       can_tick
);
  logic [2:0] cnt_q;
  logic [2:0] lim;

  // ==========================================
  // ratio to terminal count
  always_comb begin
    unique case (div_sel)
      CCB_DIV1: lim = 3'h0;
      CCB_DIV2: lim = 3'h1;
      CCB_DIV4: lim = 3'h3;
      CCB_DIV8: lim = 3'h7;
    endcase
  end

  // ==========================================
  // counter; a ratio change applies at once, wrapping on the next cycle if the count is already past the new limit
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_q    <= 3'h0;
      can_tick <= 1'b0;
    end else begin
      can_tick <= (cnt_q >= lim);
      cnt_q    <= (cnt_q >= lim) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  property p_tick_div1;
    @(posedge SYS_CLK) disable iff (RST)
    (div_sel == CCB_DIV1) [*3] |-> can_tick;
  endproperty
  a_tick_div1 : assert property (p_tick_div1)
    else $error("divide by one must tick every cycle");
endmodule : ccb_clk_div

/* File: hdl/ccb_top.sv */
// can controller clocking, register access and bit timing front end
`timescale 1ns/1ps
`include "ccb_defines.svh"
module ccb_top
  import ccb_pkg::*;
(
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output      logic [7:0] RDATA,
  // timing outputs
  output      logic       TQ_TICK,
  output      logic       BIT_START,
  output      logic [1:0] SEGMENT,
  output      logic       OVER_LIMIT
);
  // ==========================================
  // registers
  logic [7:0] cfg_q;
  logic [7:0] brp_q;
  logic [7:0] prop_q;
  logic [7:0] ph1_q;
  logic [7:0] ph2_q;
  logic [7:0] scratch_q;
  logic       can_tick;
  logic [2:0] wait_q;
  logic [7:0] last_wr_q;
  logic       read_early;
  ccb_div_e   div_sel;

  assign div_sel = ccb_div_e'(cfg_q[`CCB_DIV_MSB:`CCB_DIV_LSB]);

  ccb_clk_div u_div (
    .SYS_CLK  (SYS_CLK),
    .RST      (RST),
    .div_sel  (div_sel),
    .can_tick (can_tick)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cfg_q     <= `CCB_CFG_RESET;
      brp_q     <= `CCB_BRP_RESET;
      prop_q    <= `CCB_PROP_RESET;
      ph1_q     <= `CCB_PH1_RESET;
      ph2_q     <= `CCB_PH2_RESET;
      scratch_q <= 8'h00;
    end else if (WR) begin
      unique case (ADDR)
        `CCB_ADDR_CLK_CFG:  cfg_q     <= WDATA;
        `CCB_ADDR_BRP_EXT:  brp_q     <= WDATA;
        `CCB_ADDR_SEG_PROP: prop_q    <= WDATA;
        `CCB_ADDR_SEG_PH1:  ph1_q     <= WDATA;
        `CCB_ADDR_SEG_PH2:  ph2_q     <= WDATA;
        `CCB_ADDR_SCRATCH:  scratch_q <= WDATA;
        default: ;
      endcase
    end
  end

  // ==========================================
  // post-write window: the value crosses into the slower can domain,
  // so a same-address read inside it sees stale data (modelled as 8'h00 here)
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wait_q    <= 3'h0;
      last_wr_q <= 8'hff;
    end else if (WR) begin
      last_wr_q <= ADDR;
      unique case (div_sel)
        CCB_DIV1: wait_q <= `CCB_WAIT_DIV1;
        CCB_DIV2: wait_q <= `CCB_WAIT_DIV2;
        CCB_DIV4: wait_q <= `CCB_WAIT_DIV4;
        CCB_DIV8: wait_q <= `CCB_WAIT_DIV8;
      endcase
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
  end

  // only the just-written address is blocked; rmw is a read too
  assign read_early = (wait_q != 3'h0) && (ADDR == last_wr_q);

  // ==========================================
  // read data, one cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      if (read_early) begin
        RDATA <= 8'h00;
      end else begin
        unique case (ADDR)
          `CCB_ADDR_CLK_CFG:  RDATA <= cfg_q;
          `CCB_ADDR_BRP_EXT:  RDATA <= brp_q;
          `CCB_ADDR_SEG_PROP: RDATA <= prop_q;
          `CCB_ADDR_SEG_PH1:  RDATA <= ph1_q;
          `CCB_ADDR_SEG_PH2:  RDATA <= ph2_q;
          `CCB_ADDR_STATUS:   RDATA <= {6'h00, SEGMENT};
          `CCB_ADDR_SCRATCH:  RDATA <= scratch_q;
          default:            RDATA <= 8'h00;
        endcase
      end
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ==========================================
  // over-limit flag: ratio too small for the 250 MHz system clock
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      OVER_LIMIT <= 1'b0;
    end else begin
      OVER_LIMIT <= (`CCB_SYS_MHZ >> cfg_q[`CCB_DIV_MSB:`CCB_DIV_LSB]) > `CCB_CAN_MAX_MHZ;
    end
  end

  // ==========================================
  // time quantum: brp_q+1 can clocks; compare with >= so a smaller
  // prescaler written mid-quantum ends it at once instead of after a wrap
  logic [8:0] tq_cnt_q;
  logic       tq_pulse;
  assign tq_pulse = can_tick && (tq_cnt_q >= {1'b0, brp_q});

  always_ff @(posedge SYS_CLK) begin
    if (RST || !cfg_q[`CCB_EN_BIT]) begin
      tq_cnt_q <= 9'h000;
      TQ_TICK  <= 1'b0;
    end else begin
      TQ_TICK <= tq_pulse;
      if (can_tick) begin
        tq_cnt_q <= tq_pulse ? 9'h000 : tq_cnt_q + 9'h001;
      end
    end
  end

  // ==========================================
  // bit segments counted in whole quanta
  ccb_seg_e   seg_q;
  logic [7:0] seg_cnt_q;
  logic [7:0] seg_len;

  always_comb begin
    unique case (seg_q)
      CCB_SYNC: seg_len = `CCB_SYNC_TQ;
      CCB_PROP: seg_len = prop_q;
      CCB_PH1:  seg_len = ph1_q;
      CCB_PH2:  seg_len = ph2_q;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || !cfg_q[`CCB_EN_BIT]) begin
      seg_q     <= CCB_SYNC;
      seg_cnt_q <= 8'h00;
      BIT_START <= 1'b0;
      SEGMENT   <= CCB_SYNC;
    end else begin
      BIT_START <= tq_pulse && (seg_q == CCB_SYNC) && (seg_cnt_q == 8'h00);
      SEGMENT   <= seg_q;
      if (tq_pulse) begin
        // a zero-length segment is taken as one quantum
        if (seg_cnt_q + 8'h01 >= seg_len) begin
          seg_cnt_q <= 8'h00;
          unique case (seg_q)
            CCB_SYNC: seg_q <= CCB_PROP;
            CCB_PROP: seg_q <= CCB_PH1;
            CCB_PH1:  seg_q <= CCB_PH2;
            CCB_PH2:  seg_q <= CCB_SYNC;
          endcase
        end else begin
          seg_cnt_q <= seg_cnt_q + 8'h01;
        end
      end
    end
  end

  // ==========================================
  // checks
  property p_div1_read;
    @(posedge SYS_CLK) disable iff (RST)
    (WR && div_sel == CCB_DIV1 && ADDR == `CCB_ADDR_SCRATCH) ##1 (RD && ADDR == `CCB_ADDR_SCRATCH)
    |=> RDATA == $past(WDATA, 2);
  endproperty
  a_div1_read : assert property (p_div1_read)
    else $error("ratio one read after write is stale");
  // the divide by eight window stays shut for seven quiet cycles, no fewer, no more
  property p_wait8;
    @(posedge SYS_CLK) disable iff (RST)
    (WR && div_sel == CCB_DIV8) ##1 (!WR) [*6] |=> (ADDR != last_wr_q) || read_early;
  endproperty
  a_wait8 : assert property (p_wait8)
    else $error("divide by eight window closed early");
  property p_wait8_end;
    @(posedge SYS_CLK) disable iff (RST)
    (WR && div_sel == CCB_DIV8) ##1 (!WR) [*7] |=> !read_early;
  endproperty
  a_wait8_end : assert property (p_wait8_end)
    else $error("divide by eight window held too long");
  property p_other_reg;
    @(posedge SYS_CLK) disable iff (RST)
    WR ##1 (RD && ADDR == `CCB_ADDR_SEG_PH1 && $past(ADDR) != `CCB_ADDR_SEG_PH1) |=> RDATA == $past(ph1_q);
  endproperty
  a_other_reg : assert property (p_other_reg)
    else $error("other register delayed");
  property p_seg_order;
    @(posedge SYS_CLK) disable iff (RST)
    (seg_q == CCB_PH2) ##1 (seg_q != CCB_PH2) |-> seg_q == CCB_SYNC;
  endproperty
  a_seg_order : assert property (p_seg_order)
    else $error("phase two not followed by sync");
  property p_brp_reset;
    @(posedge SYS_CLK)
    $past(RST) |-> brp_q == `CCB_BRP_RESET;
  endproperty
  a_brp_reset : assert property (p_brp_reset)
    else $error("prescaler extension reset wrong");
endmodule : ccb_top

/* File: test/ccb_node_model.sv */
// remote node model: counts time quanta per bit
`timescale 1ns/1ps
module ccb_node_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // timing seen on the far side
  input  wire logic       tq_tick,
  input  wire logic       bit_start,
  // quanta in the last whole bit
  output      logic [7:0] bit_tq_q
);
  logic [7:0] cnt_q;
  // ==========================================
  // a tick in the bit_start cycle opens the next bit, so each bit counts whole
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q    <= 8'h00;
      bit_tq_q <= 8'h00;
    end else if (bit_start) begin
      cnt_q    <= {7'h00, tq_tick};
      bit_tq_q <= cnt_q;
    end else begin
      cnt_q <= cnt_q + {7'h00, tq_tick};
    end
  end
endmodule : ccb_node_model

/* File: test/ccb_top_tb.sv */
// self-checking bench for the can clocking front end
`timescale 1ns/1ps
`include "ccb_defines.svh"
module ccb_top_tb
  import ccb_pkg::*;
;
  logic       clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       tq_tick;
  logic       bit_start;
  logic [1:0] segment;
  logic       over_limit;
  logic [7:0] bit_tq;
  logic [7:0] q;
  int         error_cnt;
  int         n_compared;
  int         cyc = 0;
  ccb_top ccb_top_inst (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TQ_TICK(tq_tick), .BIT_START(bit_start), .SEGMENT(segment), .OVER_LIMIT(over_limit));
  ccb_node_model ccb_node_model_inst (.clk(clk), .rst(rst), .tq_tick(tq_tick), .bit_start(bit_start),
    .bit_tq_q(bit_tq));
  // ==========================================
  // clock, reset and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  // ==========================================
  // bus tasks, called just after a rising edge
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wrt(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  // data stand only in the cycle after the strobe; take them at the edge that closes it
  task rdt(input logic [7:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    q = rdata;
  endtask : rdt
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // ==========================================
  // scenarios
  task t_reset;
    rdt(`CCB_ADDR_CLK_CFG);
    chk("cfg", `CCB_CFG_RESET, q);
    rdt(`CCB_ADDR_BRP_EXT);
    chk("brp", `CCB_BRP_RESET, q);
    rdt(`CCB_ADDR_SEG_PROP);
    chk("prop", `CCB_PROP_RESET, q);
    rdt(`CCB_ADDR_SEG_PH1);
    chk("ph1", `CCB_PH1_RESET, q);
    rdt(`CCB_ADDR_SEG_PH2);
    chk("ph2", `CCB_PH2_RESET, q);
    rdt(`CCB_ADDR_STATUS);
    chk("status", 8'(CCB_SYNC), q);
    rdt(8'h3c);
    chk("unmapped", 8'h00, q);
  endtask : t_reset
  // per ratio: next-cycle reread refused above ratio one, reread after ratio minus one idle cycles served
  task t_wait;
    ccb_div_e   r;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      r = ccb_div_e'(i);
      v = 8'(8'h11 * (i + 1));
      wrt(`CCB_ADDR_CLK_CFG, {6'h00, r});
      idle(8);
      chk("over limit", 8'((`CCB_SYS_MHZ >> i) > `CCB_CAN_MAX_MHZ), {7'h00, over_limit});
      wrt(`CCB_ADDR_SCRATCH, v);
      rdt(`CCB_ADDR_SCRATCH);
      chk("reread", (i == 0) ? v : 8'h00, q);
      wrt(`CCB_ADDR_SCRATCH, ~v);
      idle((1 << i) - 1);
      rdt(`CCB_ADDR_SCRATCH);
      chk("waited", ~v, q);
      wrt(`CCB_ADDR_SCRATCH, v);
      rdt(`CCB_ADDR_SEG_PH1);
      chk("other", `CCB_PH1_RESET, q);
    end
  endtask : t_wait
  // quantum spacing in cycles and quanta per bit from the remote node
  task t_timing(input ccb_div_e r, input logic [7:0] ext, input int sp);
    int n;
    wrt(`CCB_ADDR_BRP_EXT, ext);
    idle(1);
    wrt(`CCB_ADDR_SEG_PROP, 8'h04);
    idle(1);
    wrt(`CCB_ADDR_CLK_CFG, {6'h20, r});
    idle(200);
    n = 0;
    @(negedge clk);
    while (tq_tick !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tq_tick !== 1'b1 && n < 100);
    chk("tq spacing", 8'(sp), 8'(n));
    chk("bit quanta", 8'h0a, bit_tq);
    // a bit opens in sync and shows propagation one cycle later
    n = 0;
    while (bit_start !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("bit start", 8'h01, {7'h00, bit_start});
    chk("bit sync", 8'(CCB_SYNC), {6'h00, segment});
    @(negedge clk);
    chk("bit prop", 8'(CCB_PROP), {6'h00, segment});
    @(posedge clk);
  endtask : t_timing
  // ==========================================
  // main sequence
  task results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    error_cnt  = 0;
    n_compared = 0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    idle(6);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_wait();
    t_timing(CCB_DIV1, 8'h00, 1);
    t_timing(CCB_DIV2, 8'h01, 4);
    t_timing(CCB_DIV8, 8'h02, 24);
    results();
  end
endmodule : ccb_top_tb
